// ===== design/bedc_pkg.sv
package bedc_pkg;
   // Register byte offsets.
   localparam logic [9:0] VME_ADDR_HIGH_OFS = 10'h260;
   localparam logic [9:0] VME_ADDR_LOW_OFS = 10'h264;
   localparam logic [9:0] VME_ATTR_OFS = 10'h268;
   localparam logic [9:0] PCIX_ADDR_HIGH_OFS = 10'h270;
   localparam logic [9:0] PCIX_ADDR_LOW_OFS = 10'h274;
   localparam logic [9:0] PCIX_ATTR_WORD_OFS = 10'h278;
   localparam logic [9:0] PCIX_SPLIT_OFS = 10'h27c;
   localparam logic [9:0] PCIX_CAUSE_OFS = 10'h280;
   // Field positions of both attribute registers; only valid, overflow and clear are shared.
   localparam int VALID_BIT = 31;
   localparam int OVERFLOW_BIT = 30;
   localparam int CLEAR_BIT = 29;
   localparam int ODD_TERM_BIT = 21;
   localparam int SLAVE_TERM_BIT = 20;
   localparam int BUS_ERR_BIT = 19;
   localparam int VME_SIG_HI = 18;
   localparam int VME_SIG_LO = 14;
   localparam int AM_HI = 13;
   localparam int AM_LO = 8;
   localparam int XAM_HI = 7;
   localparam int XAM_LO = 0;
   localparam int PCIX_CAUSE_HI = 16;
   localparam int PCIX_CAUSE_LO = 7;
   localparam int CMD_HI = 3;
   localparam int CMD_LO = 0;
   localparam int BE_HI = 7;
   localparam int BE_LO = 4;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // One VME exception report from the master engine.
   typedef struct packed {
      logic berr;
      logic slave_term;
      logic lwi;
      logic odd_beat;
      logic [4:0] sigs;
      logic [5:0] am;
      logic [7:0] xam;
      logic [63:0] addr;
   } bedc_vme_evt_type;

   // One PCI/X error report.
   typedef struct packed {
      logic [63:0] addr;
      logic [31:0] attr_word;
      logic [31:0] split_msg;
      logic [9:0] cause;
      logic [3:0] byte_en;
      logic [3:0] cmd;
   } bedc_pcix_evt_type;
endpackage

// ===== design/bedc_flag.sv
`timescale 1ns/100ps
`default_nettype none
// Capture-valid and overflow flag pair with write-one clear.
module bedc_flag (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control.
   input wire logic event_in,
   input wire logic clear,
   // State.
   output logic valid,
   output logic capture,
   output logic overflow
);
   logic valid_q, valid_d, over_q, over_d;

   // Capture only when empty; the clear loses to a capture in the same cycle.
   always_comb begin
      capture = event_in && !valid_q;
      valid_d = valid_q;
      over_d = over_q;
      if (clear) begin
         valid_d = 1'b0;
         over_d = 1'b0;
      end
      if (capture) begin
         valid_d = 1'b1;
      end
      if (event_in && valid_q && !clear) begin
         over_d = 1'b1;
      end
   end

   // Flag registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid_q <= 1'b0;
         over_q <= 1'b0;
      end else if (ce) begin
         valid_q <= valid_d;
         over_q <= over_d;
      end
   end

   assign valid = valid_q;
   assign overflow = over_q;
endmodule
`default_nettype wire

// ===== design/bedc_capture.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// R01: VME error, 2eVME slave end, or 2eSST last-word-invalid captures while valid clear.
// R02: A VME exception while valid is set and no clear is written keeps contents and sets overflow.
// R03: Writing one to VME clear drops valid and overflow; clear reads zero.
// R04: Odd-termination set for last-word-invalid or 2eVME odd-beat termination.
// R05: Slave-terminated set when slave ended 2eVME or 2eSST; only while valid clear.
// R06: Bus-error flag set when the transfer ended in error; only while valid clear.
// R07: LWORD, WRITE, IACK, DS1, DS0 stored in bits 18 to 14, one means asserted.
// R08: Address modifier to bits 13:8, extended modifier to 7:0, while valid clear.
// R09: PCI/X address bits 63:32 captured while PCI/X valid clear.
// R10: PCI/X address bits 31:0 captured while PCI/X valid clear.
// R11: Attribute-phase AD word captured while PCI/X valid clear.
// R12: Split completion message captured, held while PCI/X valid set.
// R13: VME address bits 63:32 captured while VME valid clear.
// R14: VME address bits 31:1 captured while VME valid clear.
// R15: A PCI/X error while valid is set and no clear is written sets overflow, keeps captures.
// R16: Writing one to PCI/X clear zeroes address and cause registers; attribute word and split message keep.
// R17: PCI/X capture also stores cause flags, command and byte-enable attribute.
module bedc_capture (
   // Clock, enable and reset.
   input wire logic CLK,
   input wire logic CLK_EN,
   input wire logic SYS_RST,
   // Exception reports from the bus engines, same clock.
   input wire logic VME_EVT_VALID,
   input wire bedc_pkg::bedc_vme_evt_type VME_EVT,
   input wire logic PCIX_EVT_VALID,
   input wire bedc_pkg::bedc_pcix_evt_type PCIX_EVT,
   // Classic Wishbone slave.
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic WB_ERR_O,
   // Flag mirrors.
   output logic VME_CAPTURE_VALID,
   output logic PCIX_CAPTURE_VALID
);
   import bedc_pkg::*;

   logic bus_req, wr_hit_attr_vme, wr_hit_attr_pcix;
   logic vme_clear, pcix_clear;
   logic vme_valid, vme_capture, vme_over;
   logic pcix_valid, pcix_capture, pcix_over;
   logic [31:0] vme_hi_q, vme_hi_d, vme_lo_q, vme_lo_d;
   logic [21:0] vme_attr_q, vme_attr_d;
   logic [31:0] px_hi_q, px_hi_d, px_lo_q, px_lo_d, px_aw_q, px_aw_d, px_sm_q, px_sm_d;
   logic [17:0] px_cause_q, px_cause_d;
   logic ack_q, ack_d, err_q, err_d;
   logic [31:0] rdat_q, rdat_d;
   logic [31:0] vme_attr_word, px_cause_word;
   logic vme_odd, vme_slave;

   // True when the address matches one of the mapped words.
   function automatic logic is_mapped(input logic [9:0] a);
      case (a)
         VME_ADDR_HIGH_OFS, VME_ADDR_LOW_OFS, VME_ATTR_OFS, PCIX_ADDR_HIGH_OFS,
         PCIX_ADDR_LOW_OFS, PCIX_ATTR_WORD_OFS, PCIX_SPLIT_OFS, PCIX_CAUSE_OFS: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // A new request is one that has not yet been answered; ack drops a cycle later.
   assign bus_req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
   assign wr_hit_attr_vme = bus_req && WB_WE_I && WB_SEL_I[3] && (WB_ADR_I == VME_ATTR_OFS);
   assign wr_hit_attr_pcix = bus_req && WB_WE_I && WB_SEL_I[3] && (WB_ADR_I == PCIX_CAUSE_OFS);
   // Writing zero to a clear bit has no effect.
   assign vme_clear = wr_hit_attr_vme && WB_DAT_I[CLEAR_BIT]; // R03
   assign pcix_clear = wr_hit_attr_pcix && WB_DAT_I[CLEAR_BIT]; // R16

   // VME flag pair.
   bedc_flag u_vme_flag (
      .clk(CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .event_in(VME_EVT_VALID),
      .clear(vme_clear),
      .valid(vme_valid),
      .capture(vme_capture),
      .overflow(vme_over)
   ); // R01 R02 R03

   // PCI/X flag pair.
   bedc_flag u_pcix_flag (
      .clk(CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .event_in(PCIX_EVT_VALID),
      .clear(pcix_clear),
      .valid(pcix_valid),
      .capture(pcix_capture),
      .overflow(pcix_over)
   ); // R15 R16

   // Termination causes derived from the VME report.
   assign vme_odd = VME_EVT.lwi || ((VME_EVT.slave_term || VME_EVT.berr) && VME_EVT.odd_beat); // R04
   assign vme_slave = VME_EVT.slave_term; // R05

   // VME capture registers load only on a capture; VME clear leaves them alone.
   always_comb begin
      vme_hi_d = vme_hi_q;
      vme_lo_d = vme_lo_q;
      vme_attr_d = vme_attr_q;
      if (vme_capture) begin
         vme_hi_d = VME_EVT.addr[63:32]; // R13
         vme_lo_d = {VME_EVT.addr[31:1], 1'b0}; // R14
         vme_attr_d[ODD_TERM_BIT] = vme_odd; // R04
         vme_attr_d[SLAVE_TERM_BIT] = vme_slave; // R05
         vme_attr_d[BUS_ERR_BIT] = VME_EVT.berr; // R06
         vme_attr_d[VME_SIG_HI:VME_SIG_LO] = VME_EVT.sigs; // R07
         vme_attr_d[AM_HI:AM_LO] = VME_EVT.am; // R08
         vme_attr_d[XAM_HI:XAM_LO] = VME_EVT.xam; // R08
      end
   end

   // PCI/X capture registers; a capture in the clear cycle wins.
   always_comb begin
      px_hi_d = px_hi_q;
      px_lo_d = px_lo_q;
      px_aw_d = px_aw_q;
      px_sm_d = px_sm_q;
      px_cause_d = px_cause_q;
      if (pcix_clear) begin
         px_hi_d = RESET_WORD; // R16
         px_lo_d = RESET_WORD;
         px_cause_d = '0;
      end
      if (pcix_capture) begin
         px_hi_d = PCIX_EVT.addr[63:32]; // R09
         px_lo_d = PCIX_EVT.addr[31:0]; // R10
         px_aw_d = PCIX_EVT.attr_word; // R11
         px_sm_d = PCIX_EVT.split_msg; // R12
         px_cause_d = {PCIX_EVT.cause, PCIX_EVT.byte_en, PCIX_EVT.cmd}; // R17
      end
   end

   // Assembled read views of the two attribute registers.
   always_comb begin
      vme_attr_word = RESET_WORD;
      vme_attr_word[VALID_BIT] = vme_valid;
      vme_attr_word[OVERFLOW_BIT] = vme_over;
      vme_attr_word[ODD_TERM_BIT:0] = vme_attr_q;
      px_cause_word = RESET_WORD;
      px_cause_word[VALID_BIT] = pcix_valid;
      px_cause_word[OVERFLOW_BIT] = pcix_over;
      px_cause_word[PCIX_CAUSE_HI:PCIX_CAUSE_LO] = px_cause_q[17:8];
      px_cause_word[BE_HI:BE_LO] = px_cause_q[7:4];
      px_cause_word[CMD_HI:CMD_LO] = px_cause_q[3:0];
   end

   // Bus answer: one-cycle ack next edge, err for unmapped addresses.
   always_comb begin
      ack_d = 1'b0;
      err_d = 1'b0;
      rdat_d = rdat_q;
      if (bus_req) begin
         ack_d = is_mapped(WB_ADR_I);
         err_d = !is_mapped(WB_ADR_I);
         case (WB_ADR_I)
            VME_ADDR_HIGH_OFS: rdat_d = vme_hi_q;
            VME_ADDR_LOW_OFS: rdat_d = vme_lo_q;
            VME_ATTR_OFS: rdat_d = vme_attr_word;
            PCIX_ADDR_HIGH_OFS: rdat_d = px_hi_q;
            PCIX_ADDR_LOW_OFS: rdat_d = px_lo_q;
            PCIX_ATTR_WORD_OFS: rdat_d = px_aw_q;
            PCIX_SPLIT_OFS: rdat_d = px_sm_q;
            PCIX_CAUSE_OFS: rdat_d = px_cause_word;
            default: rdat_d = RESET_WORD;
         endcase
      end
   end

   // All state registers; the clock enable freezes everything.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         vme_hi_q <= RESET_WORD;
         vme_lo_q <= RESET_WORD;
         vme_attr_q <= '0;
         px_hi_q <= RESET_WORD;
         px_lo_q <= RESET_WORD;
         px_aw_q <= RESET_WORD;
         px_sm_q <= RESET_WORD;
         px_cause_q <= '0;
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdat_q <= RESET_WORD;
         VME_CAPTURE_VALID <= 1'b0;
         PCIX_CAPTURE_VALID <= 1'b0;
      end else if (CLK_EN) begin
         vme_hi_q <= vme_hi_d;
         vme_lo_q <= vme_lo_d;
         vme_attr_q <= vme_attr_d;
         px_hi_q <= px_hi_d;
         px_lo_q <= px_lo_d;
         px_aw_q <= px_aw_d;
         px_sm_q <= px_sm_d;
         px_cause_q <= px_cause_d;
         ack_q <= ack_d;
         err_q <= err_d;
         rdat_q <= rdat_d;
         VME_CAPTURE_VALID <= vme_valid;
         PCIX_CAPTURE_VALID <= pcix_valid;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_ERR_O = err_q;
   assign WB_DAT_O = rdat_q;
endmodule
`default_nettype wire

// ===== test/bedc_capture_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Checks bus answers and capture flag timing at the block's ports.
module bedc_capture_sva
   import bedc_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic SYS_RST,
   // Event pulses.
   input wire logic VME_EVT_VALID,
   input wire logic PCIX_EVT_VALID,
   // Register bus.
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic WB_ERR_O,
   // Flag mirrors, which trail the internal flags by one cycle.
   input wire logic VME_CAPTURE_VALID,
   input wire logic PCIX_CAPTURE_VALID
);
   // Taken requests and clear writes; the bench always drives every byte lane.
   wire logic take = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
   wire logic clr = take && WB_WE_I && WB_DAT_I[CLEAR_BIT];
   wire logic clr_v = clr && WB_ADR_I == VME_ATTR_OFS;
   wire logic clr_p = clr && WB_ADR_I == PCIX_CAUSE_OFS;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   property p_ans; take |=> WB_ACK_O || WB_ERR_O; endproperty
   a_ans: assert property (p_ans) else $error("request not answered");
   property p_bad; take && !(WB_ADR_I inside {[10'h260:10'h280]}) |=> WB_ERR_O && !WB_ACK_O; endproperty
   a_bad: assert property (p_bad) else $error("unmapped access not refused");
   property p_clr0; take && !WB_WE_I && (WB_ADR_I == VME_ATTR_OFS || WB_ADR_I == PCIX_CAUSE_OFS)
      |=> !WB_DAT_O[CLEAR_BIT]; endproperty
   a_clr0: assert property (p_clr0) else $error("clear bit read as one");
   property p_vset; VME_EVT_VALID && !clr_v |-> ##2 VME_CAPTURE_VALID; endproperty
   a_vset: assert property (p_vset) else $error("vme valid not set");
   property p_vrise; $rose(VME_CAPTURE_VALID) |-> $past(VME_EVT_VALID, 2); endproperty
   a_vrise: assert property (p_vrise) else $error("vme valid rose alone");
   property p_vfall; $fell(VME_CAPTURE_VALID) |-> $past(clr_v, 2); endproperty
   a_vfall: assert property (p_vfall) else $error("vme valid fell alone");
   property p_pset; PCIX_EVT_VALID && !clr_p |-> ##2 PCIX_CAPTURE_VALID; endproperty
   a_pset: assert property (p_pset) else $error("pcix valid not set");
   property p_pfall; $fell(PCIX_CAPTURE_VALID) |-> $past(clr_p, 2); endproperty
   a_pfall: assert property (p_pfall) else $error("pcix valid fell alone");
   // Overflow on both sides and a refused access.
   c_vovf: cover property (VME_EVT_VALID && VME_CAPTURE_VALID);
   c_povf: cover property (PCIX_EVT_VALID && PCIX_CAPTURE_VALID);
   c_err: cover property (WB_ERR_O);
endmodule
bind bedc_capture bedc_capture_sva u_sva (.CLK, .SYS_RST, .VME_EVT_VALID, .PCIX_EVT_VALID, .WB_CYC_I, .WB_STB_I,
   .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .VME_CAPTURE_VALID, .PCIX_CAPTURE_VALID);
`default_nettype wire

// ===== test/bedc_capture_bench.sv
`timescale 1ns/100ps
`default_nettype none
// Counts every comparison and reports a mismatch at once.
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module bedc_capture_bench;
   import bedc_pkg::*;
   logic clk = 0, rst = 1, vv = 0, pv = 0, cyc = 0, stb = 0, we = 0, errq = 0, ack, err, vcap, pcap;
   logic vval = 0, vof = 0, pval = 0, pof = 0;
   logic [9:0] adr = 0;
   logic [31:0] di = 0, rd = 0, seed = 32'h0000_0042, dout;
   bedc_vme_evt_type ve = '0, v, vc = '0;
   bedc_pcix_evt_type pe = '0, x, pc = '0;
   int failures = 0, check_count = 0;
   bedc_capture DUT (.CLK(clk), .CLK_EN(1'b1), .SYS_RST(rst), .VME_EVT_VALID(vv), .VME_EVT(ve), .PCIX_EVT_VALID(pv),
      .PCIX_EVT(pe), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(di),
      .WB_DAT_O(dout), .WB_ACK_O(ack), .WB_ERR_O(err), .VME_CAPTURE_VALID(vcap), .PCIX_CAPTURE_VALID(pcap));
   // Clock of 40 ns period.
   always #20 clk = ~clk;
   // Xorshift source, so every run draws the same stimulus.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Classic single cycle; the answer and read data are taken at the rising edge that shows ack.
   task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, di} <= {2'h3, w, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (!(ack | err) && n < 50);
      {rd, errq} = {dout, err};
      {cyc, stb, we} <= 3'h0;
      if (n >= 50) failures++;
   endtask
   // One-cycle exception pulse on the chosen side.
   task automatic fire(input logic p);
      @(posedge clk);
      {pv, vv, ve, pe} <= {p, !p, v, x};
      @(posedge clk);
      {pv, vv} <= 2'h0;
   endtask
   task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
      wb(0, a, 0);
      `CHK(rd, e)
   endtask
   // Reads back all eight registers against the model.
   task automatic check_all();
      `CHK(vcap, vval)
      `CHK(pcap, pval)
      rdchk(VME_ADDR_HIGH_OFS, vc.addr[63:32]);
      rdchk(VME_ADDR_LOW_OFS, {vc.addr[31:1], 1'b0});
      rdchk(VME_ATTR_OFS, {vval, vof, 8'h00,
         vc.lwi | (vc.odd_beat & (vc.berr | vc.slave_term)), vc.slave_term, vc.berr, vc.sigs, vc.am, vc.xam});
      rdchk(PCIX_ADDR_HIGH_OFS, pc.addr[63:32]);
      rdchk(PCIX_ADDR_LOW_OFS, pc.addr[31:0]);
      rdchk(PCIX_ATTR_WORD_OFS, pc.attr_word);
      rdchk(PCIX_SPLIT_OFS, pc.split_msg);
      rdchk(PCIX_CAUSE_OFS, {pval, pof, 13'h0000, pc.cause[9:1], pc.byte_en, pc.cmd});
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Far beyond the thousand or so cycles the rounds need, so only a hang trips it.
   initial begin
      #2_000_000;
      failures++;
      complete_run();
   end
   // Rounds of captures, overflows, ignored writes, clears and refused accesses.
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      check_all();
      for (int i = 0; i < 12; i++) begin
         repeat (1 + i % 2) begin
            v = $bits(v)'({rnd(), rnd(), rnd()});
            x = $bits(x)'({rnd(), rnd(), rnd(), rnd(), rnd()});
            {v.berr, v.slave_term, v.lwi} = 3'h1 << (i % 3);
            fire(i[1]);
            if (i[1]) begin
               pc = pval ? pc : x;
               {pval, pof} = {1'b1, pof | pval};
            end else begin
               vc = vval ? vc : v;
               {vval, vof} = {1'b1, vof | vval};
            end
         end
         wb(1, i[1] ? PCIX_CAUSE_OFS : VME_ATTR_OFS, rnd() & 32'hdfff_ffff);
         wb(1, i[1] ? PCIX_ADDR_LOW_OFS : VME_ADDR_HIGH_OFS, rnd());
         check_all();
         wb(1, i[1] ? PCIX_CAUSE_OFS : VME_ATTR_OFS, 32'h2000_0000);
         if (i[1]) {pval, pof, pc.addr, pc.cause, pc.byte_en, pc.cmd} = '0;
         else {vval, vof} = 2'h0;
         wb(i[0], 10'h284 + 10'(4 * i), rnd());
         `CHK(errq, 1'b1)
         check_all();
         $display("Round %0d done", i);
      end
      complete_run();
   end
endmodule
`default_nettype wire
